// ==== iop_pkg.sv ====
`default_nettype none
package iop_pkg;

    localparam int NPORT = 9;
    localparam int ADDR_W = 12;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [6:0] WIN_LAST = 7'h7F;
    localparam logic [6:0] IX_P1_DATA = 7'h01;
    localparam logic [6:0] IX_P1_DIR = 7'h04;
    localparam logic [6:0] IX_P2_DATA = 7'h06;
    localparam logic [6:0] IX_P2_FSEL = 7'h09;
    localparam logic [6:0] IX_P5_DATA = 7'h0D;
    localparam logic [6:0] IX_P5_DIR = 7'h10;
    localparam logic [6:0] IX_P5_FSEL = 7'h11;
    localparam logic [6:0] IX_P6_DATA = 7'h12;
    localparam logic [6:0] IX_P7_DATA = 7'h13;
    localparam logic [6:0] IX_P6_FSEL = 7'h15;
    localparam logic [6:0] IX_P7_DIR = 7'h16;
    localparam logic [6:0] IX_P7_FSEL = 7'h17;
    localparam logic [6:0] IX_P8_DATA = 7'h18;
    localparam logic [6:0] IX_P9_DATA = 7'h19;
    localparam logic [6:0] IX_P8_DIR = 7'h1A;
    localparam logic [6:0] IX_P8_FSEL = 7'h1B;
    localparam logic [6:0] IX_PA_DATA = 7'h1E;
    localparam logic [6:0] IX_PB_DATA = 7'h1F;
    localparam logic [6:0] IX_PA_DIR = 7'h2C;
    localparam logic [6:0] IX_PA_FSEL = 7'h2D;
    localparam logic [6:0] IX_PB_DIR = 7'h2E;
    localparam logic [6:0] IX_PB_FSEL = 7'h2F;
    localparam logic [6:0] IX_NONE = 7'h00;

    // ------------------------------------------------------------
    // Per-port tables, element order P1 P2 P5 P6 P7 P8 P9 PA PB
    // ------------------------------------------------------------
    localparam logic [0:8][6:0] DAT_IX = {IX_P1_DATA, IX_P2_DATA,
        IX_P5_DATA, IX_P6_DATA, IX_P7_DATA, IX_P8_DATA, IX_P9_DATA,
        IX_PA_DATA, IX_PB_DATA};
    localparam logic [0:8][6:0] DIR_IX = {IX_P1_DIR, IX_NONE, IX_P5_DIR,
        IX_NONE, IX_P7_DIR, IX_P8_DIR, IX_NONE, IX_PA_DIR, IX_PB_DIR};
    localparam logic [0:8][6:0] FS_IX = {IX_NONE, IX_P2_FSEL, IX_P5_FSEL,
        IX_P6_FSEL, IX_P7_FSEL, IX_P8_FSEL, IX_NONE, IX_PA_FSEL,
        IX_PB_FSEL};
    localparam logic [0:8][7:0] DAT_WMASK = {8'hFF, 8'hFF, 8'h3D, 8'h3F,
        8'hFF, 8'h3F, 8'h00, 8'h0F, 8'hFF};
    localparam logic [0:8][7:0] DAT_RMASK = {8'hFF, 8'hFF, 8'h3D, 8'h3F,
        8'hFF, 8'h3F, 8'h0F, 8'h0F, 8'hFF};
    localparam logic [0:8][7:0] DIR_MASK = {8'hFF, 8'h00, 8'h3C, 8'h00,
        8'hFF, 8'h3F, 8'h00, 8'h0F, 8'hFF};
    localparam logic [0:8][7:0] FS_MASK = {8'h00, 8'hFF, 8'h3C, 8'h3F,
        8'hFF, 8'h2D, 8'h00, 8'h0C, 8'h4C};
    localparam logic [0:8][7:0] PU_MASK = {8'h00, 8'h00, 8'h3C, 8'h00,
        8'hFF, 8'h3F, 8'h00, 8'h0F, 8'hFF};
    localparam logic [0:8][7:0] DAT_RST = {8'h00, 8'hFF, 8'h3D, 8'h3F,
        8'hFF, 8'h3F, 8'h00, 8'h0F, 8'hFF};
    localparam logic [0:8][7:0] DIR_RST = {8'h00, 8'hFF, 8'h00, 8'hFF,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [0:8][7:0] FS_RST = {8'h00, 8'hFF, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam int P5_SLOT = 2;
    localparam int RDE_BIT = 0;

    typedef enum logic [1:0] {
        IOP_K_NONE = 2'b00,
        IOP_K_DATA = 2'b01,
        IOP_K_DIR = 2'b10,
        IOP_K_FSEL = 2'b11
    } iop_kind_e;

    typedef struct packed {
        iop_kind_e kind;
        logic [3:0] slot;
    } iop_sel_s;

    typedef struct packed {
        logic [7:0] dat;
        logic [7:0] dir;
        logic [7:0] fsel;
    } iop_port_s;

endpackage
`default_nettype wire

// ==== iop_port_bank.sv ====
// The implementer's own choice: register access over APB.
`default_nettype none
module iop_port_bank
    import iop_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Port pins
    input wire logic [NPORT-1:0][7:0] pin_in,
    output logic [NPORT-1:0][7:0] pin_out,
    output logic [NPORT-1:0][7:0] pin_oe,
    output logic [NPORT-1:0][7:0] pullup_en,
    // Alternate peripheral and bus signals
    input wire logic [NPORT-1:0][7:0] alt_out,
    input wire logic [NPORT-1:0][7:0] alt_oe,
    // CPU read cycle and read strobe pin
    input wire logic cpu_rd,
    input wire logic cpu_rd_ext,
    output logic rd_strobe_n
);

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic iop_sel_s decode(input logic [6:0] ix);
        iop_sel_s s;
        s.kind = IOP_K_NONE;
        s.slot = 4'h0;
        for (int p = 0; p < NPORT; p++) begin
            if (ix == DAT_IX[p]) begin
                s.kind = IOP_K_DATA;
                s.slot = 4'(p);
            end else if (ix == DIR_IX[p] && ix != IX_NONE) begin
                s.kind = IOP_K_DIR;
                s.slot = 4'(p);
            end else if (ix == FS_IX[p] && ix != IX_NONE) begin
                s.kind = IOP_K_FSEL;
                s.slot = 4'(p);
            end
        end
        return s;
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [NPORT-1:0][7:0] meta_ff;
    logic [NPORT-1:0][7:0] sync_ff;

    genvar g;
    generate
        for (g = 0; g < NPORT; g++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta_ff[g] <= 8'h00;
                    sync_ff[g] <= 8'h00;
                end else begin
                    meta_ff[g] <= pin_in[g];
                    sync_ff[g] <= meta_ff[g];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Register file and APB answer
    // ------------------------------------------------------------
    iop_port_s [NPORT-1:0] cfg_ff;
    iop_port_s [NPORT-1:0] nxt_cfg;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic pready_ff;
    logic nxt_pready;
    logic pslverr_ff;
    logic nxt_pslverr;
    iop_sel_s sel;
    logic in_win;
    logic access;
    logic [7:0] rd_byte;
    logic [7:0] wbyte;

    always_comb begin
        nxt_cfg = cfg_ff;
        nxt_prdata = prdata_ff;
        nxt_pslverr = pslverr_ff;
        rd_byte = 8'h00;
        wbyte = pwdata[7:0];
        // Only indices 0..7F exist; anything above is not ours.
        in_win = (paddr[ADDR_W-1:9] == '0) && (paddr[1:0] == 2'b00)
            && (paddr[8:2] <= WIN_LAST);
        sel = decode(paddr[8:2]);
        access = psel && penable && pready_ff;
        // Answer one cycle into the access phase, never later.
        nxt_pready = psel && !penable;
        if (psel && !penable) begin
            nxt_pslverr = !in_win;
            if (in_win && !pwrite) begin
                if (sel.kind == IOP_K_DATA) begin
                    // Outputs read the latch, the strobe enable reads latch OR pin,
                    // inputs read the pin.
                    rd_byte = ((cfg_ff[sel.slot].dir
                        | (sel.slot == 4'(P5_SLOT) ? 8'h01 : 8'h00))
                        & cfg_ff[sel.slot].dat)
                        | (~cfg_ff[sel.slot].dir & sync_ff[sel.slot]);
                    rd_byte = rd_byte & DAT_RMASK[sel.slot];
                end else begin
                    // Direction and function selects never read back.
                    rd_byte = 8'h00;
                end
            end
            nxt_prdata = {24'h000000, rd_byte};
        end
        if (access && pwrite && in_win) begin
            if (sel.kind == IOP_K_DATA) begin
                // Port 9 has no writable bits, so a write is dropped.
                nxt_cfg[sel.slot].dat =
                    (cfg_ff[sel.slot].dat & ~DAT_WMASK[sel.slot])
                    | (wbyte & DAT_WMASK[sel.slot]);
            end else if (sel.kind == IOP_K_DIR) begin
                nxt_cfg[sel.slot].dir =
                    (cfg_ff[sel.slot].dir & ~DIR_MASK[sel.slot])
                    | (wbyte & DIR_MASK[sel.slot]);
            end else if (sel.kind == IOP_K_FSEL) begin
                nxt_cfg[sel.slot].fsel =
                    (cfg_ff[sel.slot].fsel & ~FS_MASK[sel.slot])
                    | (wbyte & FS_MASK[sel.slot]);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int p = 0; p < NPORT; p++) begin
                cfg_ff[p].dat <= DAT_RST[p];
                cfg_ff[p].dir <= DIR_RST[p];
                cfg_ff[p].fsel <= FS_RST[p];
            end
            prdata_ff <= 32'h00000000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            cfg_ff <= nxt_cfg;
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;

    // ------------------------------------------------------------
    // Pin drivers and pull-ups
    // ------------------------------------------------------------
    logic [NPORT-1:0][7:0] pout_ff;
    logic [NPORT-1:0][7:0] poe_ff;
    logic [NPORT-1:0][7:0] pup_ff;
    logic [NPORT-1:0][7:0] nxt_pout;
    logic [NPORT-1:0][7:0] nxt_poe;
    logic [NPORT-1:0][7:0] nxt_pup;

    always_comb begin
        for (int p = 0; p < NPORT; p++) begin
            // A selected alternate function owns both level and enable.
            nxt_pout[p] = (cfg_ff[p].fsel & alt_out[p])
                | (~cfg_ff[p].fsel & cfg_ff[p].dat);
            nxt_poe[p] = (cfg_ff[p].fsel & alt_oe[p])
                | (~cfg_ff[p].fsel & cfg_ff[p].dir);
            // The latch of an input bit switches its pull-up, so a
            // read-modify-write would copy pin levels into it.
            nxt_pup[p] = cfg_ff[p].dat & ~nxt_poe[p] & PU_MASK[p];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pout_ff <= '0;
            poe_ff <= '0;
            pup_ff <= '0;
        end else begin
            pout_ff <= nxt_pout;
            poe_ff <= nxt_poe;
            pup_ff <= nxt_pup;
        end
    end

    assign pin_out = pout_ff;
    assign pin_oe = poe_ff;
    assign pullup_en = pup_ff;

    // ------------------------------------------------------------
    // Read strobe
    // ------------------------------------------------------------
    logic rd_n_ff;
    logic nxt_rd_n;
    logic read_strobe_internal_enable;

    always_comb begin
        read_strobe_internal_enable = cfg_ff[P5_SLOT].dat[RDE_BIT];
        // Pseudo-static memory needs the strobe on internal reads too.
        if (!read_strobe_internal_enable) begin
            nxt_rd_n = !cpu_rd;
        end else begin
            nxt_rd_n = !(cpu_rd && cpu_rd_ext);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_n_ff <= 1'b1;
        end else begin
            rd_n_ff <= nxt_rd_n;
        end
    end

    assign rd_strobe_n = rd_n_ff;

endmodule
`default_nettype wire

// ==== iop_port_bank_dummy_never.sv ====
`default_nettype none
`default_nettype wire

// ==== iop_port_bank_asserts.sv ====
`default_nettype none
module iop_port_bank_asserts
    import iop_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Register bus
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins and strobe
    input wire logic [NPORT-1:0][7:0] pin_oe,
    input wire logic [NPORT-1:0][7:0] pullup_en,
    input wire logic cpu_rd,
    input wire logic cpu_rd_ext,
    input wire logic rd_strobe_n
);
    logic rde_ff;
    logic nxt_rde;
    logic wr_dir;
    logic acc;
    assign acc = psel && penable && pready && pwrite;
    assign wr_dir = acc && paddr == 12'h010;
    always_comb begin
        nxt_rde = rde_ff;
        if (acc && paddr == 12'h034) begin
            nxt_rde = pwdata[0];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rde_ff <= 1'b1;
        end else begin
            rde_ff <= nxt_rde;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_rd_internal: assert property
        (cpu_rd && !rde_ff |=> !rd_strobe_n)
        else $error("strobe missing on internal read");
    a_rd_external: assert property
        (cpu_rd && cpu_rd_ext |=> !rd_strobe_n)
        else $error("strobe missing on external read");
    a_rd_quiet: assert property
        (!cpu_rd || (rde_ff && !cpu_rd_ext) |=> rd_strobe_n)
        else $error("strobe not expected");
    a_win_error: assert property
        (psel && !penable && paddr[11:9] != 3'h0 |=> pready && pslverr)
        else $error("outside window not refused");
    a_win_ok: assert property (psel && !penable && paddr[11:9] == 3'h0
        && paddr[1:0] == 2'h0 |=> pready && !pslverr)
        else $error("bad answer");
    a_wo_zero: assert property (psel && !penable && !pwrite && paddr
        inside {12'h010, 12'h024, 12'h0BC} |=> prdata == 32'h0)
        else $error("write-only bits read back");
    a_oe_cause: assert property
        (!$stable(pin_oe[0]) |-> $past(wr_dir, 2))
        else $error("drive changed without direction write");
    a_pull_undriven: assert property ((pullup_en & pin_oe) == '0)
        else $error("pull-up on a driven pin");
    c_err: cover property (pready && pslverr);
    c_strobe: cover property (cpu_rd && !rde_ff ##1 !rd_strobe_n);
    c_oe: cover property (!$stable(pin_oe[0]));
endmodule
bind iop_port_bank iop_port_bank_asserts chk_u (.pclk, .presetn, .paddr,
    .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .pin_oe,
    .pullup_en, .cpu_rd, .cpu_rd_ext, .rd_strobe_n);
`default_nettype wire

// ==== iop_pin_model.sv ====
`default_nettype none
module iop_pin_model
    import iop_pkg::*;
(
    // Device side
    input wire logic [NPORT-1:0][7:0] pin_out,
    input wire logic [NPORT-1:0][7:0] pin_oe,
    input wire logic [NPORT-1:0][7:0] pullup_en,
    // Outside circuitry
    input wire logic [NPORT-1:0][7:0] ext_val,
    input wire logic [NPORT-1:0][7:0] ext_en,
    output logic [NPORT-1:0][7:0] pin_in
);
    // A floating pin without pull-up shows the inverse of its current pin_out.
    assign pin_in = (pin_oe & pin_out)
        | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en & (pullup_en | ~pin_out));
endmodule
`default_nettype wire

// ==== test_io_port_sfr_bank.sv ====
`default_nettype none
module test_io_port_sfr_bank
    import iop_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = '0, prdata;
    logic pready, pslverr, cpu_rd = 1'b0, cpu_rd_ext = 1'b0, rd_strobe_n;
    logic [NPORT-1:0][7:0] pin_in, pin_out, pin_oe, pullup_en;
    logic [NPORT-1:0][7:0] alt_out = '0, alt_oe = '0;
    logic [NPORT-1:0][7:0] ext_val = '0, ext_en = '1;
    logic [32:0] exp_q[$];
    logic [32:0] e;
    logic xrd_n;
    logic [7:0] lfsr = 8'h4F;
    int n_errors = 0, check_count = 0;
    always #25 pclk = ~pclk;
    iop_port_bank dut_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe,
        .pullup_en, .alt_out, .alt_oe, .cpu_rd, .cpu_rd_ext, .rd_strobe_n);
    iop_pin_model pm_u (.pin_out, .pin_oe, .pullup_en, .ext_val, .ext_en,
        .pin_in);
    function automatic logic [7:0] rnd(logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic apb(logic [11:0] a, logic w, logic [31:0] d,
        logic [32:0] x);
        exp_q.push_back(x);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(logic [11:0] a, logic [7:0] x);
        apb(a, 1'b0, 32'h0, {25'h0, x});
    endtask
    task automatic wr(logic [11:0] a, logic [7:0] d);
        apb(a, 1'b1, {24'h0, d}, 33'h0);
    endtask
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            chk("slverr", {31'h0, pslverr}, {31'h0, e[32]});
            if (!pwrite) chk("rdata", prdata, e[31:0]);
        end
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        @(posedge pclk);
        for (int k = 0; k < NPORT; k++) begin
            lfsr = rnd(lfsr);
            ext_val[k] <= lfsr;
            alt_out[k] <= ~lfsr;
        end
        alt_oe <= '1;
        repeat (19) @(posedge pclk);
        presetn <= 1'b1;
        // The pin registers load the reset contents one edge after release.
        repeat (2) @(posedge pclk);
        chk("pull", {24'h0, pullup_en[4]}, 32'hFF);
        rd(12'h018, 8'hFF);
        rd(12'h004, ext_val[0]);
        rd(12'h010, 8'h00);
        rd(12'h024, 8'h00);
        rd(12'h0BC, 8'h00);
        rd(12'h008, 8'h00);
        wr(12'h064, 8'hFF);
        rd(12'h064, ext_val[6] & 8'h0F);
        $display("access kinds test done");
        wr(12'h010, 8'hFF);
        wr(12'h004, lfsr);
        rd(12'h004, lfsr);
        apb(12'h005, 1'b1, 32'h0, {1'b1, 32'h0});
        apb(12'h204, 1'b1, 32'h0, {1'b1, 32'h0});
        rd(12'h004, lfsr);
        chk("oe", {24'h0, pin_oe[0]}, 32'hFF);
        chk("out", {24'h0, pin_out[0]}, {24'h0, lfsr});
        wr(12'h04C, 8'h5A);
        // Pin outputs follow the register one edge after the write.
        @(posedge pclk);
        chk("pull", {24'h0, pullup_en[4]}, 32'h5A);
        wr(12'h058, 8'hFF);
        wr(12'h05C, 8'hFF);
        @(posedge pclk);
        chk("alt", {24'h0, pin_out[4]}, {24'h0, alt_out[4]});
        chk("pull", {24'h0, pullup_en[4]}, 32'h0);
        $display("port drive test done");
        for (int i = 0; i < 8; i++) begin
            if (i == 4) wr(12'h034, 8'h3C);
            cpu_rd <= i[0];
            cpu_rd_ext <= i[1];
            @(posedge pclk);
            @(negedge pclk);
            xrd_n = !(i[0] && (i[2] || i[1]));
            chk("strobe", {31'h0, rd_strobe_n}, {31'h0, xrd_n});
            @(posedge pclk);
        end
        cpu_rd <= 1'b0;
        $display("read strobe test done");
        wrap_up();
    end
    initial begin
        #200000;
        n_errors++;
        wrap_up();
    end
endmodule
`default_nettype wire
